// *** irrx_defs.vh ***
// Register map, field positions, reset values and timing of the receiver
`ifndef IRRX_DEFS_VH
`define IRRX_DEFS_VH

`define IRRX_OFF_LEADER 8'h00
`define IRRX_OFF_RXCTRL 8'h04
`define IRRX_OFF_THRESH 8'h08
`define IRRX_OFF_FILTER 8'h0C
`define IRRX_OFF_ENABLE 8'h10
`define IRRX_OFF_STATUS 8'h14
`define IRRX_OFF_BUF1 8'h18
`define IRRX_OFF_BUF2 8'h1C
`define IRRX_OFF_BUF3 8'h20

`define IRRX_LEADER_RST 32'h0000_0000
`define IRRX_RXCTRL_RST 32'h0000_0000
`define IRRX_THRESH_RST 32'h0000_0000
`define IRRX_FILTER_RST 32'h0000_0000

`define IRRX_RXCTRL_LEADERLESS 16
`define IRRX_RXCTRL_PHASE 17
`define IRRX_FILTER_INVERT 4
`define IRRX_ST_DONE 0
`define IRRX_ST_MAXCYC 1
`define IRRX_ST_LOWW 2

`define IRRX_CLK_MHZ 125
`define IRRX_SAMPLE_NS 32
`define IRRX_SAMPLE_DIV ((`IRRX_SAMPLE_NS * `IRRX_CLK_MHZ + 999) / 1000)

`endif

// *** irrx_filter.v ***
// Input synchroniser, polarity inversion and noise filter
`timescale 1ns/100ps
`include "irrx_defs.vh"

module irrx_filter (
    input wire clk,
    input wire sys_rst,
    input wire sample_tick,
    input wire ir_in,
    input wire invert,
    input wire [3:0] noise_filter_cycles,
    output reg level_r
);

reg sync1_r;
reg sync2_r;
reg [3:0] run_r;
wire sample;

assign sample = sync2_r ^ invert;

always @(posedge clk) begin
    if (sys_rst) begin
        sync1_r <= 1'b1;
        sync2_r <= 1'b1;
    end else begin
        sync1_r <= ir_in;
        sync2_r <= sync1_r;
    end
end

// Opposite level must persist for the set number of samples
always @(posedge clk) begin
    if (sys_rst) begin
        level_r <= 1'b1;
        run_r <= 4'h0;
    end else if (sample_tick) begin
        if (sample == level_r) begin
            run_r <= 4'h0;
        end else if (run_r + 4'h1 >= noise_filter_cycles) begin
            level_r <= sample;
            run_r <= 4'h0;
        end else begin
            run_r <= run_r + 4'h1;
        end
    end
end

endmodule

// *** irrx_decode.v ***
// Bit decoder for cycle-modulation and phase-method intervals
`timescale 1ns/100ps

module irrx_decode (
    input wire phase_mode,
    input wire [8:0] cycle,
    input wire [6:0] thr_lo,
    input wire [6:0] thr_hi,
    input wire prev_bit,
    output reg [1:0] nbits,
    output reg [1:0] bits
);

function ge_thr;
    input [8:0] c;
    input [6:0] t;
    begin
        ge_thr = (c >= {2'b00, t});
    end
endfunction

wire above_lo;
wire above_hi;

assign above_lo = ge_thr(cycle, thr_lo);
assign above_hi = ge_thr(cycle, thr_hi);

always @* begin
    nbits = 2'd1;
    bits = 2'b00;
    if (!phase_mode) begin
        bits = {1'b0, above_lo};
    end else if (prev_bit) begin
        // From mid-bit falling edge: 1T, 1.5T, 2T
        if (!above_lo) begin
            bits = 2'b01;
        end else if (!above_hi) begin
            nbits = 2'd2;
            bits = 2'b00;
        end else begin
            nbits = 2'd2;
            bits = 2'b01;
        end
    end else begin
        // From bit-boundary falling edge: 1T or 1.5T only
        if (!above_lo) begin
            bits = 2'b00;
        end else if (!above_hi) begin
            bits = 2'b01;
        end else begin
            nbits = 2'd0;
        end
    end
end

endmodule

// *** irrx_receiver.v ***
// Infrared remote receiver: leader detection, bit decoding, registers
//
// Contract
// - bit cycles measured between falling edges
// - cycle mode classifies bit by lower threshold
// - end on maximum bit cycle or low
// - on completion pulse interrupt, await leader
// - phase enable selects phase-method decoding
// - phase mode compares against two thresholds
// - three patterns about 1T, 1.5T, 2T
// - lower threshold splits pattern one, two
// - upper threshold splits pattern two, three
// - phase bit from pattern and previous bit
// - completed phase bits held in buffers
// - cycle at or above threshold is one
// - disabling reception stops and discards data
// - filter needs consecutive opposite samples
`timescale 1ns/100ps
`include "irrx_defs.vh"

module irrx_receiver #(
    parameter SAMPLE_DIV = `IRRX_SAMPLE_DIV
) (
    input wire clk,
    input wire sys_rst,
    input wire ir_in,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_we,
    input wire reg_re,
    output reg [31:0] reg_rdata_r,
    output reg rx_complete_r
);

localparam BUF_BITS = 96;
localparam ST_IDLE = 2'd0;
localparam ST_LEAD = 2'd1;
localparam ST_DATA = 2'd2;

reg [31:0] leader_config_reg_r;
reg [31:0] receive_control_reg_r;
reg [31:0] threshold_config_reg_r;
reg [31:0] input_filter_config_reg_r;
reg receive_enable_r;
reg [2:0] status_r;
reg [6:0] done_count_r;
reg [BUF_BITS-1:0] rx_buf_r;
reg [BUF_BITS-1:0] shift_r;
reg [6:0] bit_count_r;
reg [1:0] state_r;
reg [1:0] state_nxt;
reg [7:0] div_r;
reg sample_tick_r;
reg level_prev_r;
reg [8:0] cyc_cnt_r;
reg [8:0] low_cnt_r;
reg [8:0] low_w_r;
reg prev_bit_r;

wire level;
wire fall_ev;
wire rise_ev;
wire [7:0] ll_min;
wire [7:0] ll_max;
wire [7:0] lc_min;
wire [7:0] lc_max;
wire [7:0] max_bit_cycle;
wire [7:0] excess_low_width;
wire leaderless_accept;
wire phase_mode_enable;
wire [1:0] dec_nbits;
wire [1:0] dec_bits;
wire lead_ok;
wire lead_alt;
wire maxcyc_hit;
wire loww_hit;
wire start_data;
wire finish;

assign ll_min = leader_config_reg_r[7:0];
assign ll_max = leader_config_reg_r[15:8];
assign lc_min = leader_config_reg_r[23:16];
assign lc_max = leader_config_reg_r[31:24];
assign max_bit_cycle = receive_control_reg_r[7:0];
assign excess_low_width = receive_control_reg_r[15:8];
assign leaderless_accept = receive_control_reg_r[`IRRX_RXCTRL_LEADERLESS];
assign phase_mode_enable = receive_control_reg_r[`IRRX_RXCTRL_PHASE];

function [8:0] sat_inc;
    input [8:0] v;
    begin
        sat_inc = (v == 9'h1FF) ? v : v + 9'h001;
    end
endfunction

// Sampling clock enable
always @(posedge clk) begin
    if (sys_rst) begin
        div_r <= 8'h00;
        sample_tick_r <= 1'b0;
    end else if (div_r >= SAMPLE_DIV[7:0] - 8'h01) begin
        div_r <= 8'h00;
        sample_tick_r <= 1'b1;
    end else begin
        div_r <= div_r + 8'h01;
        sample_tick_r <= 1'b0;
    end
end

irrx_filter u_filter (
    .clk(clk),
    .sys_rst(sys_rst),
    .sample_tick(sample_tick_r),
    .ir_in(ir_in),
    .invert(input_filter_config_reg_r[`IRRX_FILTER_INVERT]),
    .noise_filter_cycles(input_filter_config_reg_r[3:0]),
    .level_r(level)
);

irrx_decode u_decode (
    .phase_mode(phase_mode_enable),
    .cycle(cyc_cnt_r),
    .thr_lo(threshold_config_reg_r[6:0]),
    .thr_hi(threshold_config_reg_r[14:8]),
    .prev_bit(prev_bit_r),
    .nbits(dec_nbits),
    .bits(dec_bits)
);

assign fall_ev = level_prev_r & ~level;
assign rise_ev = ~level_prev_r & level;

// Leader cycle window, low width checked unless its maximum is zero
assign lead_ok = (cyc_cnt_r >= {1'b0, lc_min}) &&
                 (cyc_cnt_r <= {1'b0, lc_max}) &&
                 ((ll_max == 8'h00) ||
                  ((low_w_r > {1'b0, ll_min}) &&
                   (low_w_r < {1'b0, ll_max})));
assign lead_alt = leaderless_accept && (low_w_r < {1'b0, ll_max});

assign start_data = fall_ev && ((state_r == ST_IDLE && lc_max == 8'h00) ||
                    (state_r == ST_LEAD && (lead_ok || lead_alt)));
assign maxcyc_hit = (state_r == ST_DATA) && !fall_ev &&
                    (max_bit_cycle != 8'h00) &&
                    (cyc_cnt_r >= {1'b0, max_bit_cycle});
assign loww_hit = (state_r == ST_DATA) && !level && !fall_ev &&
                  (excess_low_width != 8'h00) &&
                  (low_cnt_r >= {1'b0, excess_low_width});
assign finish = (maxcyc_hit || loww_hit) && (bit_count_r != 7'd0);

always @* begin
    state_nxt = state_r;
    case (state_r)
        ST_IDLE: begin
            if (start_data) begin
                state_nxt = ST_DATA;
            end else if (fall_ev) begin
                state_nxt = ST_LEAD;
            end
        end
        ST_LEAD: begin
            if (start_data) begin
                state_nxt = ST_DATA;
            end else if (!fall_ev && lc_max != 8'h00 &&
                         cyc_cnt_r > {1'b0, lc_max}) begin
                state_nxt = ST_IDLE;
            end
        end
        ST_DATA: begin
            if (maxcyc_hit || loww_hit) begin
                state_nxt = ST_IDLE;
            end
        end
        default: begin
            state_nxt = ST_IDLE;
        end
    endcase
    if (!receive_enable_r) begin
        state_nxt = ST_IDLE;
    end
end

// Interval and low-width counters in sampling periods
always @(posedge clk) begin
    if (sys_rst) begin
        level_prev_r <= 1'b1;
        cyc_cnt_r <= 9'h000;
        low_cnt_r <= 9'h000;
        low_w_r <= 9'h000;
    end else begin
        level_prev_r <= level;
        if (fall_ev) begin
            cyc_cnt_r <= 9'h000;
            low_cnt_r <= 9'h000;
        end else if (sample_tick_r) begin
            cyc_cnt_r <= sat_inc(cyc_cnt_r);
            if (!level) begin
                low_cnt_r <= sat_inc(low_cnt_r);
            end
        end
        if (rise_ev) begin
            low_w_r <= low_cnt_r;
        end
    end
end

// Bit shifting and completion
always @(posedge clk) begin
    if (sys_rst) begin
        state_r <= ST_IDLE;
        shift_r <= {BUF_BITS{1'b0}};
        bit_count_r <= 7'd0;
        prev_bit_r <= 1'b1;
        rx_buf_r <= {BUF_BITS{1'b0}};
        done_count_r <= 7'd0;
        rx_complete_r <= 1'b0;
    end else begin
        state_r <= state_nxt;
        rx_complete_r <= 1'b0;
        if (!receive_enable_r) begin
            shift_r <= {BUF_BITS{1'b0}};
            bit_count_r <= 7'd0;
        end else if (start_data) begin
            // Phase frames open with 11; the first 1 precedes any edge
            shift_r <= {{(BUF_BITS-1){1'b0}}, phase_mode_enable};
            bit_count_r <= phase_mode_enable ? 7'd1 : 7'd0;
            prev_bit_r <= 1'b1;
        end else if (state_r == ST_DATA && fall_ev) begin
            if (dec_nbits == 2'd2) begin
                shift_r <= {shift_r[BUF_BITS-3:0], dec_bits};
                bit_count_r <= (bit_count_r >= 7'd95) ? 7'd96 :
                               bit_count_r + 7'd2;
                prev_bit_r <= dec_bits[0];
            end else if (dec_nbits == 2'd1) begin
                shift_r <= {shift_r[BUF_BITS-2:0], dec_bits[0]};
                bit_count_r <= (bit_count_r >= 7'd96) ? 7'd96 :
                               bit_count_r + 7'd1;
                prev_bit_r <= dec_bits[0];
            end
        end else if (finish) begin
            rx_buf_r <= shift_r;
            done_count_r <= bit_count_r;
            rx_complete_r <= 1'b1;
        end
    end
end

// Register writes; hardware set wins over write-one-to-clear
always @(posedge clk) begin
    if (sys_rst) begin
        leader_config_reg_r <= `IRRX_LEADER_RST;
        receive_control_reg_r <= `IRRX_RXCTRL_RST;
        threshold_config_reg_r <= `IRRX_THRESH_RST;
        input_filter_config_reg_r <= `IRRX_FILTER_RST;
        receive_enable_r <= 1'b0;
        status_r <= 3'b000;
    end else begin
        if (reg_we) begin
            case (reg_addr)
                `IRRX_OFF_LEADER: begin
                    leader_config_reg_r <= reg_wdata;
                end
                `IRRX_OFF_RXCTRL: begin
                    receive_control_reg_r <= {14'h0000, reg_wdata[17:0]};
                end
                `IRRX_OFF_THRESH: begin
                    threshold_config_reg_r <= {17'h0_0000, reg_wdata[14:8],
                                               1'b0, reg_wdata[6:0]};
                end
                `IRRX_OFF_FILTER: begin
                    input_filter_config_reg_r <= {27'h000_0000,
                                                  reg_wdata[4:0]};
                end
                `IRRX_OFF_ENABLE: begin
                    receive_enable_r <= reg_wdata[0];
                end
                default: begin
                end
            endcase
        end
        status_r <= (reg_we && reg_addr == `IRRX_OFF_STATUS) ?
                    (status_r & ~reg_wdata[2:0]) : status_r;
        if (finish) begin
            status_r[`IRRX_ST_DONE] <= 1'b1;
            status_r[`IRRX_ST_MAXCYC] <= maxcyc_hit;
            status_r[`IRRX_ST_LOWW] <= loww_hit;
        end
    end
end

// Read data in the cycle after the strobe
always @(posedge clk) begin
    if (sys_rst) begin
        reg_rdata_r <= 32'h0000_0000;
    end else if (reg_re) begin
        case (reg_addr)
            `IRRX_OFF_LEADER: reg_rdata_r <= leader_config_reg_r;
            `IRRX_OFF_RXCTRL: reg_rdata_r <= receive_control_reg_r;
            `IRRX_OFF_THRESH: reg_rdata_r <= threshold_config_reg_r;
            `IRRX_OFF_FILTER: reg_rdata_r <= input_filter_config_reg_r;
            `IRRX_OFF_ENABLE: begin
                reg_rdata_r <= {31'h0000_0000, receive_enable_r};
            end
            `IRRX_OFF_STATUS: begin
                reg_rdata_r <= {14'h0000, state_r, 1'b0, done_count_r,
                                5'h00, status_r};
            end
            `IRRX_OFF_BUF1: reg_rdata_r <= rx_buf_r[31:0];
            `IRRX_OFF_BUF2: reg_rdata_r <= rx_buf_r[63:32];
            `IRRX_OFF_BUF3: reg_rdata_r <= rx_buf_r[95:64];
            default: reg_rdata_r <= 32'h0000_0000;
        endcase
    end else begin
        reg_rdata_r <= 32'h0000_0000;
    end
end

endmodule

// *** irrx_checker.sv ***
// Port-level assertions for the infrared remote receiver
`timescale 1ns/100ps
`include "irrx_defs.vh"
module irrx_checker (
    input wire clk,
    input wire sys_rst,
    input wire ir_in,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_we,
    input wire reg_re,
    input wire [31:0] reg_rdata_r,
    input wire rx_complete_r
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    chk_pulse_single: assert property (
        rx_complete_r |=> !rx_complete_r [*4])
        else $error("completion pulse too long");
    chk_done_idle: assert property (
        rx_complete_r ##[1:4] (reg_re && reg_addr == `IRRX_OFF_STATUS)
        |=> reg_rdata_r[0] && reg_rdata_r[17:16] == 2'b00)
        else $error("not idle after completion");
    chk_stop_quiet: assert property (
        reg_we && reg_addr == `IRRX_OFF_ENABLE && !reg_wdata[0]
        |-> ##2 !rx_complete_r [*8])
        else $error("completion after disable");
    chk_stop_idle: assert property (
        (reg_we && reg_addr == `IRRX_OFF_ENABLE && !reg_wdata[0]) ##2
        (reg_re && reg_addr == `IRRX_OFF_STATUS)
        |=> reg_rdata_r[17:16] == 2'b00)
        else $error("state kept after disable");
    chk_thresh_back: assert property (
        (reg_we && reg_addr == `IRRX_OFF_THRESH) ##2
        (reg_re && reg_addr == `IRRX_OFF_THRESH) |=>
        reg_rdata_r[14:8] == $past(reg_wdata[14:8], 3) &&
        reg_rdata_r[6:0] == $past(reg_wdata[6:0], 3))
        else $error("threshold readback wrong");
    chk_filter_back: assert property (
        (reg_we && reg_addr == `IRRX_OFF_FILTER) ##2
        (reg_re && reg_addr == `IRRX_OFF_FILTER) |=>
        reg_rdata_r[4:0] == $past(reg_wdata[4:0], 3))
        else $error("filter readback wrong");
    chk_rdata_idle: assert property (
        !reg_re |=> reg_rdata_r == 32'h0000_0000)
        else $error("read data without read");
    chk_end_quiet: assert property (
        rx_complete_r |-> $stable(ir_in) &&
        $past(ir_in, 2) == $past(ir_in, 3))
        else $error("completion while line moving");
endmodule

bind irrx_receiver irrx_checker u_chk (
    .clk(clk),
    .sys_rst(sys_rst),
    .ir_in(ir_in),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_we(reg_we),
    .reg_re(reg_re),
    .reg_rdata_r(reg_rdata_r),
    .rx_complete_r(rx_complete_r)
);

// *** irrx_ir_src.sv ***
// Infrared line source emitting falling-edge interval frames
`timescale 1ns/100ps
module irrx_ir_src #(
    parameter DIV = 2
) (
    input wire clk,
    output wire ir_in
);
    reg lvl_r = 1'b1;
    reg inv_r = 1'b0;
    // Sent inverted for frames whose bits start on a rise
    assign ir_in = lvl_r ^ inv_r;
    task set_inv(input bit v);
        inv_r <= v;
    endtask
    task hold(input bit v, input int ticks);
        lvl_r <= v;
        repeat (ticks * DIV) @(posedge clk);
    endtask
    // Intervals are fall to fall, leader first, then a closing fall
    task frame(input int d[$], input int tail);
        foreach (d[i]) begin
            hold(1'b0, 4);
            hold(1'b1, d[i] - 4);
        end
        hold(1'b0, tail);
        hold(1'b1, 4);
    endtask
endmodule

// *** test_ir_remote_low_leader_phase_rx.sv ***
// Self-checking bench for the infrared remote receiver
`timescale 1ns/100ps
`include "irrx_defs.vh"
module test_ir_remote_low_leader_phase_rx;
    localparam DIV = 2;
    reg clk = 1'b0;
    reg sys_rst = 1'b1;
    reg [7:0] reg_addr = 8'h00;
    reg [31:0] reg_wdata = 32'h0000_0000;
    reg reg_we = 1'b0;
    reg reg_re = 1'b0;
    wire ir_in;
    wire [31:0] reg_rdata_r;
    wire rx_complete_r;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int pulses = 0;
    int exp_n = 0;
    int d[$];
    logic [31:0] rv;
    logic [95:0] exp_sh;

    always #4 clk = ~clk;

    irrx_receiver #(.SAMPLE_DIV(DIV)) uut (
        .clk(clk),
        .sys_rst(sys_rst),
        .ir_in(ir_in),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_we(reg_we),
        .reg_re(reg_re),
        .reg_rdata_r(reg_rdata_r),
        .rx_complete_r(rx_complete_r)
    );
    irrx_ir_src #(.DIV(DIV)) src (.clk(clk), .ir_in(ir_in));

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (rx_complete_r === 1'b1) pulses <= pulses + 1;
        if (cycles == 60000) begin
            errors++;
            wrap_up();
        end
    end

    task wrap_up();
        if (errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_re <= 1'b0;
        @(posedge clk);
        rv = reg_rdata_r;
    endtask
    task push(input bit b);
        exp_sh = {exp_sh[94:0], b};
        if (exp_n < 96) exp_n++;
    endtask
    task rearm();
        wr(`IRRX_OFF_ENABLE, 32'h0000_0000);
        wr(`IRRX_OFF_ENABLE, 32'h0000_0001);
        exp_sh = '0;
        exp_n = 0;
        d = {30};
    endtask
    task expect_frame(input int tgt, input logic [2:0] st);
        int k;
        k = 0;
        while (pulses < tgt && k < 4000) begin
            @(posedge clk);
            k++;
        end
        check(pulses, tgt);
        rd(`IRRX_OFF_STATUS);
        check(rv, {14'h0, 3'b000, 7'(exp_n), 5'h00, st});
        for (int i = 0; i < 3; i++) begin
            rd(`IRRX_OFF_BUF1 + 8'(i * 4));
            check(rv, exp_sh[i * 32 +: 32]);
        end
        wr(`IRRX_OFF_STATUS, 32'h0000_0007);
    endtask

    initial begin
        int p;
        int b;
        rv = $urandom(60181);
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            rd(8'(i * 4));
            check(rv, 32'h0000_0000);
        end
        rv = $urandom();
        p = rv;
        wr(`IRRX_OFF_THRESH, rv);
        rd(`IRRX_OFF_THRESH);
        check(rv, p & 32'h0000_7F7F);
        // Cycle-only leader, settings made while disabled
        wr(`IRRX_OFF_LEADER, 32'h2814_0000);
        wr(`IRRX_OFF_RXCTRL, 32'h0000_0A1E);
        wr(`IRRX_OFF_THRESH, 32'h0000_140C);
        wr(`IRRX_OFF_FILTER, 32'h0000_0002);
        rd(`IRRX_OFF_FILTER);
        check(rv, 32'h0000_0002);
        rearm();
        for (int i = 0; i < 40; i++) begin
            b = (i < 2) ? 11 + i : $urandom_range(18, 6);
            d.push_back(b);
            push(b >= 12);
        end
        src.frame(d, 4);
        expect_frame(1, 3'b011);
        // No leader, then a leader refused on width but accepted anyway
        for (int m = 0; m < 2; m++) begin
            wr(`IRRX_OFF_LEADER, m ? 32'h2814_0805 : 32'h0000_0000);
            wr(`IRRX_OFF_RXCTRL, m ? 32'h0001_0A1E : 32'h0000_0A1E);
            rearm();
            if (m == 0) d.delete();
            for (int i = 0; i < 8; i++) begin
                b = $urandom_range(18, 6);
                d.push_back(b);
                push(b >= 12);
            end
            src.frame(d, 4);
            expect_frame(2 + m, 3'b011);
        end
        wr(`IRRX_OFF_LEADER, 32'h2814_0000);
        // Phase frame, T of 8 ticks: 1T, 1.5T and 2T intervals
        wr(`IRRX_OFF_THRESH, 32'h0000_0E0A);
        wr(`IRRX_OFF_RXCTRL, 32'h0002_0A1E);
        rearm();
        push(1'b1);
        for (int i = 0; i < 24; i++) begin
            b = (i == 0) ? 8 : 4 * $urandom_range(exp_sh[0] ? 4 : 3, 2);
            p = exp_sh[0];
            d.push_back(b);
            if (b == 8) begin
                push(p);
            end else if (p) begin
                push(1'b0);
                push(b == 16);
            end else begin
                push(1'b1);
            end
        end
        src.frame(d, 4);
        expect_frame(4, 3'b011);
        wr(`IRRX_OFF_ENABLE, 32'h0000_0000);
        wr(`IRRX_OFF_RXCTRL, 32'h0000_0A1E);
        wr(`IRRX_OFF_THRESH, 32'h0000_140C);
        src.set_inv(1'b1);
        wr(`IRRX_OFF_FILTER, 32'h0000_0012);
        rearm();
        for (int i = 0; i < 12; i++) begin
            b = $urandom_range(18, 6);
            d.push_back(b);
            push(b >= 12);
        end
        src.frame(d, 40);
        expect_frame(5, 3'b101);
        // Disable in mid-frame; buffers keep the last whole frame
        wr(`IRRX_OFF_ENABLE, 32'h0000_0001);
        d = {30};
        repeat (10) d.push_back(10);
        fork
            src.frame(d, 4);
            begin
                repeat (160) @(posedge clk);
                wr(`IRRX_OFF_ENABLE, 32'h0000_0000);
                rd(`IRRX_OFF_STATUS);
                check(rv[17:16], 32'h0000_0000);
            end
        join
        repeat (200) @(posedge clk);
        check(pulses, 5);
        rd(`IRRX_OFF_BUF1);
        check(rv, exp_sh[31:0]);
        // Short glitch filtered, longer low starts leader
        src.set_inv(1'b0);
        wr(`IRRX_OFF_FILTER, 32'h0000_0003);
        wr(`IRRX_OFF_ENABLE, 32'h0000_0001);
        src.hold(1'b0, 2);
        src.hold(1'b1, 10);
        rd(`IRRX_OFF_STATUS);
        check(rv[17:16], 32'h0000_0000);
        src.hold(1'b0, 4);
        src.hold(1'b1, 2);
        rd(`IRRX_OFF_STATUS);
        check(rv[17:16], 32'h0000_0001);
        wr(`IRRX_OFF_ENABLE, 32'h0000_0000);
        wrap_up();
    end
endmodule
